//--- design/rsc_reset_source.sv
`timescale 1ns/1ns
`include "rsc_regs.svh"

module rsc_reset_source (
  input wire logic clk_sys,
  input wire logic nrst,
  // Special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic [7:0] sfrRdData,
  // Reset pin, open drain
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOe,
  // Analog and detector inputs
  input wire logic supplyAbove,
  input wire logic compOut,
  input wire logic oneShotExpired,
  // Watchdog link to the counter array
  input wire logic wdtOverflow,
  input wire logic wdtDisable,
  output logic wdtEnable,
  output logic wdtTick,
  // Flash access monitoring
  input wire logic flashWriteEnable,
  input wire logic xdataWrite,
  input wire logic [15:0] xdataAddr,
  input wire logic codeRead,
  input wire logic [15:0] codeAddr,
  input wire logic branchFetch,
  input wire logic [15:0] fetchAddr,
  input wire logic securityFault,
  // Results
  output logic sysRstN,
  output logic monitorEnable,
  output logic stallDetectEnable
);

  import rsc_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  rsc_state_t state_q;
  rsc_state_t state_d;
  rsc_cause_t cause_q;
  rsc_cause_t pending_q;
  rsc_cause_t request;
  logic [7:0] holdCnt_q;
  logic [`RSC_SYNC_W-1:0] pinsAsync;
  logic [`RSC_SYNC_W-1:0] pinsSync;
  logic pinLow;
  logic supplyOk;
  logic compHigh;
  logic stallSeen;
  logic supplySel;
  logic stallSel;
  logic compSel;
  logic flashErr;
  logic swForce_q;
  logic stillActive;
  logic holdDone;
  logic resetRelease;
  logic running;
  logic wrCause;
  logic wrSupply;
  logic pinDrive;

  // ----------------------------------------
  // Pin and analog synchronisers
  // ----------------------------------------
  assign pinsAsync = {oneShotExpired, compOut, supplyAbove, rstPinIn};

  rsc_sync u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .asyncIn(pinsAsync),
    .syncOut(pinsSync)
  );

  // Stall input leaves the sync as one after reset; harmless, the detector is unselected then
  assign pinLow = !pinsSync[0];
  assign supplyOk = pinsSync[1];
  assign compHigh = pinsSync[2];
  assign stallSeen = pinsSync[3];

  // Cause bits double as source selects while running
  assign supplySel = cause_q[`RSC_CAUSE_POR_BIT];
  assign stallSel = cause_q[`RSC_CAUSE_STALL_BIT];
  assign compSel = cause_q[`RSC_CAUSE_COMP_BIT];

  assign running = (state_q == RSC_RUN);
  assign wrCause = running && sfrWr && (sfrAddr == `RSC_ADDR_CAUSE);
  assign wrSupply = running && sfrWr && (sfrAddr == `RSC_ADDR_SUPPLY_CTRL);

  // ----------------------------------------
  // Flash address checks
  // ----------------------------------------
  always_comb begin
    flashErr = 1'b0;
    if (flashWriteEnable && xdataWrite && (xdataAddr > `RSC_FLASH_LAST_USER)) begin
      flashErr = 1'b1;
    end
    if (codeRead && (codeAddr > `RSC_FLASH_LAST_USER)) begin
      flashErr = 1'b1;
    end
    if (branchFetch && (fetchAddr > `RSC_FLASH_LAST_USER)) begin
      flashErr = 1'b1;
    end
    if (securityFault) begin
      flashErr = 1'b1;
    end
  end

  // ----------------------------------------
  // Reset requests, one bit per cause position
  // ----------------------------------------
  always_comb begin
    request = '0;
    request[`RSC_CAUSE_PIN_BIT] = pinLow;
    request[`RSC_CAUSE_POR_BIT] = monitorEnable && supplySel && !supplyOk;
    request[`RSC_CAUSE_STALL_BIT] = stallSel && stallSeen;
    request[`RSC_CAUSE_WDT_BIT] = wdtEnable && wdtOverflow;
    request[`RSC_CAUSE_SW_BIT] = swForce_q;
    request[`RSC_CAUSE_COMP_BIT] = compSel && !compHigh;
    request[`RSC_CAUSE_FLASH_BIT] = flashErr;
  end

  // Level sources keep the device in reset while they persist
  assign stillActive = pinLow
    || (pending_q[`RSC_CAUSE_POR_BIT] && !supplyOk)
    || (pending_q[`RSC_CAUSE_COMP_BIT] && !compHigh);
  assign holdDone = (holdCnt_q == 8'((`RSC_HOLD_CYC) - 1));

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      RSC_RUN: begin
        if (request != '0) begin
          state_d = RSC_HOLD;
        end
      end
      RSC_HOLD: begin
        if (holdDone && !stillActive) begin
          state_d = RSC_RELEASE;
        end
      end
      RSC_RELEASE: begin
        state_d = RSC_RUN;
      end
      default: begin
        state_d = RSC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q <= RSC_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  assign resetRelease = (state_q == RSC_RELEASE);

  // ----------------------------------------
  // Hold counter
  // ----------------------------------------
  // Minimum hold, so a one-cycle request still gives a full reset pulse
  always_ff @(posedge clk_sys) begin
    if (!nrst || running) begin
      holdCnt_q <= 8'h00;
    end else if (state_q == RSC_HOLD && !holdDone) begin
      holdCnt_q <= holdCnt_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Cause capture; first cause wins by fixed priority
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pending_q <= rsc_cause_t'(`RSC_CAUSE_RESET);
    end else if (running && request != '0) begin
      pending_q <= '0;
      if (request[`RSC_CAUSE_POR_BIT]) begin
        pending_q[`RSC_CAUSE_POR_BIT] <= 1'b1;
      end else if (request[`RSC_CAUSE_PIN_BIT]) begin
        pending_q[`RSC_CAUSE_PIN_BIT] <= 1'b1;
      end else if (request[`RSC_CAUSE_STALL_BIT]) begin
        pending_q[`RSC_CAUSE_STALL_BIT] <= 1'b1;
      end else if (request[`RSC_CAUSE_COMP_BIT]) begin
        pending_q[`RSC_CAUSE_COMP_BIT] <= 1'b1;
      end else if (request[`RSC_CAUSE_WDT_BIT]) begin
        pending_q[`RSC_CAUSE_WDT_BIT] <= 1'b1;
      end else if (request[`RSC_CAUSE_FLASH_BIT]) begin
        pending_q[`RSC_CAUSE_FLASH_BIT] <= 1'b1;
      end else begin
        pending_q[`RSC_CAUSE_SW_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Reset cause register
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cause_q <= rsc_cause_t'(`RSC_CAUSE_RESET);
    end else if (resetRelease) begin
      cause_q <= pending_q;
    end else if (wrCause) begin
      cause_q[`RSC_CAUSE_POR_BIT] <= sfrWrData[`RSC_CAUSE_POR_BIT];
      cause_q[`RSC_CAUSE_STALL_BIT] <= sfrWrData[`RSC_CAUSE_STALL_BIT];
      cause_q[`RSC_CAUSE_COMP_BIT] <= sfrWrData[`RSC_CAUSE_COMP_BIT];
    end
  end

  // Write of one to the force bit requests reset on the next edge
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      swForce_q <= 1'b0;
    end else begin
      swForce_q <= wrCause && sfrWrData[`RSC_CAUSE_SW_BIT];
    end
  end

  // ----------------------------------------
  // Supply monitor enable
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      monitorEnable <= `RSC_SMC_ENABLE_RESET;
    end else if (wrSupply) begin
      monitorEnable <= sfrWrData[`RSC_SMC_ENABLE_BIT];
    end
  end

  // ----------------------------------------
  // Stalled clock detector enable
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stallDetectEnable <= 1'b0;
    end else begin
      stallDetectEnable <= stallSel;
    end
  end

  // ----------------------------------------
  // Register reads, answered one cycle later
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sfrRdData <= 8'h00;
    end else if (sfrRd && sfrAddr == `RSC_ADDR_SUPPLY_CTRL) begin
      sfrRdData <= {monitorEnable, supplyOk, `RSC_SMC_UNUSED_READ};
    end else if (sfrRd && sfrAddr == `RSC_ADDR_CAUSE) begin
      sfrRdData <= {1'b0, cause_q};
    end else begin
      sfrRdData <= 8'h00;
    end
  end

  // ----------------------------------------
  // Internal reset and reset pin
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sysRstN <= 1'b0;
    end else begin
      sysRstN <= (state_d == RSC_RUN);
    end
  end

  // Only power-on and supply resets pull the pin
  // Drive lets go once hold is met and supply is good; the pin's own
  // low would otherwise keep the sequencer in hold for ever
  always_comb begin
    pinDrive = 1'b0;
    if (state_d == RSC_HOLD) begin
      if (running) begin
        pinDrive = request[`RSC_CAUSE_POR_BIT];
      end else begin
        pinDrive = pending_q[`RSC_CAUSE_POR_BIT] && !(holdDone && supplyOk);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rstPinOe <= 1'b1;
      rstPinOut <= 1'b0;
    end else begin
      rstPinOut <= 1'b0;
      rstPinOe <= pinDrive;
    end
  end

  // ----------------------------------------
  // Watchdog enable and clock
  // ----------------------------------------
  rsc_wdt_clk u_wdt (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .resetRelease(resetRelease),
    .wdtDisable(wdtDisable),
    .wdtEnable(wdtEnable),
    .wdtTick(wdtTick)
  );

endmodule : rsc_reset_source

//--- design/rsc_regs.svh
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define RSC_ADDR_SUPPLY_CTRL 8'hff
`define RSC_ADDR_CAUSE 8'hef

// ----------------------------------------
// Supply monitor control fields
// ----------------------------------------
`define RSC_SMC_ENABLE_BIT 7
`define RSC_SMC_STATUS_BIT 6
`define RSC_SMC_ENABLE_RESET 1'b1
`define RSC_SMC_UNUSED_READ 6'h00

// ----------------------------------------
// Reset cause register fields
// ----------------------------------------
`define RSC_CAUSE_PIN_BIT 0
`define RSC_CAUSE_POR_BIT 1
`define RSC_CAUSE_STALL_BIT 2
`define RSC_CAUSE_WDT_BIT 3
`define RSC_CAUSE_SW_BIT 4
`define RSC_CAUSE_COMP_BIT 5
`define RSC_CAUSE_FLASH_BIT 6
`define RSC_CAUSE_RESET 7'h02

// ----------------------------------------
// Flash limits
// ----------------------------------------
`define RSC_FLASH_LAST_USER 16'h3dff

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSC_CLK_MHZ 125
`define RSC_HOLD_NS 100
`define RSC_HOLD_CYC ((`RSC_HOLD_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_WDT_DIV 12
`define RSC_SYNC_W 4

`endif

//--- design/rsc_pkg.sv
package rsc_pkg;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    RSC_RUN = 3'b001,
    RSC_HOLD = 3'b010,
    RSC_RELEASE = 3'b100
  } rsc_state_t;

  typedef logic [6:0] rsc_cause_t;

endpackage : rsc_pkg

//--- design/rsc_sync.sv
`timescale 1ns/1ns
`include "rsc_regs.svh"

module rsc_sync (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [`RSC_SYNC_W-1:0] asyncIn,
  output logic [`RSC_SYNC_W-1:0] syncOut
);

  logic [`RSC_SYNC_W-1:0] stage1_q;

  // ----------------------------------------
  // Two flops per bit; first stage feeds only the second
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `RSC_SYNC_W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          stage1_q[i] <= 1'b1;
          syncOut[i] <= 1'b1;
        end else begin
          stage1_q[i] <= asyncIn[i];
          syncOut[i] <= stage1_q[i];
        end
      end
    end
  endgenerate

endmodule : rsc_sync

//--- design/rsc_wdt_clk.sv
`timescale 1ns/1ns
`include "rsc_regs.svh"

module rsc_wdt_clk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic resetRelease,
  input wire logic wdtDisable,
  output logic wdtEnable,
  output logic wdtTick
);

  logic [3:0] divCnt_q;

  // ----------------------------------------
  // Watchdog enable, set again after every reset
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wdtEnable <= 1'b1;
    end else if (resetRelease) begin
      wdtEnable <= 1'b1;
    end else if (wdtDisable) begin
      wdtEnable <= 1'b0;
    end
  end

  // ----------------------------------------
  // System clock divided by twelve, as an enable pulse
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst || resetRelease) begin
      divCnt_q <= 4'h0;
      wdtTick <= 1'b0;
    end else if (divCnt_q == 4'((`RSC_WDT_DIV) - 1)) begin
      divCnt_q <= 4'h0;
      wdtTick <= 1'b1;
    end else begin
      divCnt_q <= divCnt_q + 4'h1;
      wdtTick <= 1'b0;
    end
  end

endmodule : rsc_wdt_clk

//--- bench/rsc_reset_source_monitor.sv
`timescale 1ns/1ns
`include "rsc_regs.svh"
// ----------------------------------------
// Port checks
// ----------------------------------------
module rsc_reset_source_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrRdData,
  input wire logic rstPinIn,
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  input wire logic supplyAbove,
  input wire logic oneShotExpired,
  input wire logic wdtOverflow,
  input wire logic wdtEnable,
  input wire logic wdtTick,
  input wire logic sysRstN,
  input wire logic monitorEnable,
  input wire logic stallDetectEnable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_pin_forces_reset: assert property (!rstPinIn [*4] |-> !sysRstN) else $error("pin low while running");
  a_pin_left_alone: assert property (sysRstN && $past(sysRstN) |-> !rstPinOe && !rstPinOut)
    else $error("pin driven while running");
  a_stall_resets: assert property ((oneShotExpired && stallDetectEnable && sysRstN) [*3] |=> !sysRstN)
    else $error("stall ignored");
  // Sync delay is covered by asking for a steady input first
  a_supply_status: assert property ($stable(supplyAbove) [*4] ##0 (sfrRd && sfrAddr == `RSC_ADDR_SUPPLY_CTRL && sysRstN)
    |=> sfrRdData[6] == $past(supplyAbove) && sfrRdData[5:0] == 6'h00) else $error("supply status wrong");
  a_enable_readback: assert property (sfrRd && sfrAddr == `RSC_ADDR_SUPPLY_CTRL && sysRstN
    |=> sfrRdData[7] == $past(monitorEnable)) else $error("enable readback wrong");
  a_enable_sticky: assert property (!sysRstN && $past(nrst) |-> $stable(monitorEnable)) else $error("enable moved");
  a_wdt_on_exit: assert property ($rose(sysRstN) |-> wdtEnable) else $error("watchdog off after reset");
  a_wdt_resets: assert property (wdtOverflow && wdtEnable && sysRstN |=> !sysRstN) else $error("overflow ignored");
  a_tick_spacing: assert property (wdtTick |=> !wdtTick [*8] ##1 !wdtTick [*3]) else $error("tick early");
  a_hold_min: assert property ($fell(sysRstN) |-> !sysRstN [*8] ##1 !sysRstN [*5]) else $error("reset too short");
  c_release: cover property ($rose(sysRstN));
  c_overflow: cover property (wdtOverflow && wdtEnable && sysRstN);
  c_pin: cover property (!rstPinIn && sysRstN);
endmodule : rsc_reset_source_monitor

bind rsc_reset_source rsc_reset_source_monitor mon_u (.clk_sys, .nrst, .sfrAddr, .sfrRd, .sfrRdData,
  .rstPinIn, .rstPinOut, .rstPinOe, .supplyAbove, .oneShotExpired, .wdtOverflow, .wdtEnable, .wdtTick,
  .sysRstN, .monitorEnable, .stallDetectEnable);

//--- bench/rsc_pin_driver.sv
`timescale 1ns/1ns
// ----------------------------------------
// Outside reset circuit, pull-up on the pin
// ----------------------------------------
module rsc_pin_driver (
  input wire logic clk_sys,
  input wire logic [7:0] pulseLen,
  input wire logic pulseGo,
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  output logic rstPinIn
);
  logic [7:0] cnt_q = 8'h00;
  always @(posedge clk_sys) begin
    if (pulseGo) begin
      cnt_q <= pulseLen;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // Open drain: pull-up wins only when nobody pulls low
  assign rstPinIn = !((rstPinOe && !rstPinOut) || cnt_q != 8'h00);
endmodule : rsc_pin_driver

//--- bench/tb_top.sv
`timescale 1ns/1ns
`include "rsc_regs.svh"
module tb_top;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, pulseLen = 8'h00, sfrRdData, d;
  logic sfrWr = 1'h0, sfrRd = 1'h0, supplyAbove = 1'h1, compOut = 1'h1, oneShotExpired = 1'h0;
  logic wdtOverflow = 1'h0, wdtDisable = 1'h0, flashWriteEnable = 1'h0, xdataWrite = 1'h0;
  logic codeRead = 1'h0, branchFetch = 1'h0, securityFault = 1'h0, pulseGo = 1'h0, monEn = 1'h1;
  logic [15:0] xdataAddr = 16'h0000, codeAddr = 16'h0000, fetchAddr = 16'h0000;
  logic rstPinIn, rstPinOut, rstPinOe, wdtEnable, wdtTick, sysRstN, monitorEnable, stallDetectEnable;
  int failures = 0, tests_run = 0, seed = 91, n;
  always #4 clk_sys = ~clk_sys;
  rsc_reset_source dut_u (.clk_sys, .nrst, .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrRdData, .rstPinIn,
    .rstPinOut, .rstPinOe, .supplyAbove, .compOut, .oneShotExpired, .wdtOverflow, .wdtDisable, .wdtEnable,
    .wdtTick, .flashWriteEnable, .xdataWrite, .xdataAddr, .codeRead, .codeAddr, .branchFetch, .fetchAddr,
    .securityFault, .sysRstN, .monitorEnable, .stallDetectEnable);
  rsc_pin_driver pin_u (.clk_sys, .pulseLen, .pulseGo, .rstPinOut, .rstPinOe, .rstPinIn);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] exp_cause(input int k);
    case (k)
      0: return 8'h01;
      1: return 8'h04;
      2: return 8'h20;
      3: return 8'h08;
      4: return 8'h40;
      5: return 8'h10;
      default: return 8'h02;
    endcase
  endfunction : exp_cause
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    sfrAddr <= a;
    sfrWrData <= v;
    sfrWr <= 1'h1;
    @(posedge clk_sys);
    sfrWr <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    sfrAddr <= a;
    sfrRd <= 1'h1;
    @(posedge clk_sys);
    sfrRd <= 1'h0;
    #1 d = sfrRdData;
  endtask : rd
  // Bounded wait for the internal reset to reach a level; n keeps the cycle count
  task automatic wait_lvl(input logic v, input int lim);
    n = 0;
    #1;
    while (sysRstN !== v && n < lim) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("sysRstN", {7'h0, v}, {7'h0, sysRstN});
  endtask : wait_lvl
  task automatic report_and_stop;
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    failures++;
    report_and_stop;
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'h1;
    wait_lvl(1'h1, 80);
    rd(`RSC_ADDR_CAUSE);
    chk("cause", 8'h02, d);
    rd(`RSC_ADDR_SUPPLY_CTRL);
    chk("supplyCtrl", 8'hc0, d);
    chk("wdtEnable", 8'h01, {7'h0, wdtEnable});
    rd(8'h10);
    chk("unmapped", 8'h00, d);
    // Sources that are off or unselected, flash exactly at the last legal byte
    wr(`RSC_ADDR_SUPPLY_CTRL, 8'h3f);
    monEn = 1'h0;
    supplyAbove <= 1'h0;
    compOut <= 1'h0;
    oneShotExpired <= 1'h1;
    flashWriteEnable <= 1'h1;
    xdataWrite <= 1'h1;
    codeRead <= 1'h1;
    branchFetch <= 1'h1;
    xdataAddr <= 16'h3dff;
    codeAddr <= 16'h3dff;
    fetchAddr <= 16'h3dff;
    @(posedge clk_sys);
    wdtDisable <= 1'h1;
    @(posedge clk_sys);
    wdtDisable <= 1'h0;
    wdtOverflow <= 1'h1;
    @(posedge clk_sys);
    wdtOverflow <= 1'h0;
    repeat (8) @(posedge clk_sys);
    wait_lvl(1'h1, 0);
    chk("wdtOff", 8'h00, {7'h0, wdtEnable});
    rd(`RSC_ADDR_SUPPLY_CTRL);
    chk("supplyLow", 8'h00, d);
    {supplyAbove, compOut, oneShotExpired} <= 3'h6;
    {flashWriteEnable, xdataWrite, codeRead, branchFetch} <= 4'h0;
    wr(`RSC_ADDR_CAUSE, 8'h04);
    @(posedge clk_sys);
    #1 chk("stallOn", 8'h01, {7'h0, stallDetectEnable});
    wr(`RSC_ADDR_CAUSE, 8'h00);
    @(posedge clk_sys);
    #1 chk("stallOff", 8'h00, {7'h0, stallDetectEnable});
    for (int k = 0; k < 7; k++) begin
      @(posedge clk_sys);
      case (k)
        0: begin
          pulseLen <= 8'h04 + 8'($unsigned($random(seed)) % 40);
          pulseGo <= 1'h1;
        end
        1: begin
          wr(`RSC_ADDR_CAUSE, 8'h04);
          oneShotExpired <= 1'h1;
        end
        2: begin
          wr(`RSC_ADDR_CAUSE, 8'h20);
          compOut <= 1'h0;
        end
        3: wdtOverflow <= 1'h1;
        4: begin
          xdataAddr <= 16'h3e00 + 16'($unsigned($random(seed)) % 32'hc200);
          codeAddr <= 16'h3e00 + 16'($unsigned($random(seed)) % 32'hc200);
          fetchAddr <= 16'h3e00 + 16'($unsigned($random(seed)) % 32'hc200);
          case ($unsigned($random(seed)) % 4)
            0: {flashWriteEnable, xdataWrite} <= 2'h3;
            1: codeRead <= 1'h1;
            2: branchFetch <= 1'h1;
            default: securityFault <= 1'h1;
          endcase
        end
        5: wr(`RSC_ADDR_CAUSE, 8'h10);
        default: begin
          wr(`RSC_ADDR_SUPPLY_CTRL, 8'h80);
          monEn = 1'h1;
          repeat (20) @(posedge clk_sys);
          wr(`RSC_ADDR_CAUSE, 8'h02);
          supplyAbove <= 1'h0;
        end
      endcase
      @(posedge clk_sys);
      pulseGo <= 1'h0;
      wdtOverflow <= 1'h0;
      wait_lvl(1'h0, 30);
      chk("pinDrive", {7'h0, k == 6}, {7'h0, rstPinOe});
      {supplyAbove, compOut, oneShotExpired, securityFault} <= 4'hc;
      {flashWriteEnable, xdataWrite, codeRead, branchFetch} <= 4'h0;
      wait_lvl(1'h1, 200);
      chk("holdLong", 8'h01, {7'h0, n >= 13});
      rd(`RSC_ADDR_CAUSE);
      chk("cause", exp_cause(k), d);
      rd(`RSC_ADDR_SUPPLY_CTRL);
      chk("supplyCtrl", {monEn, 7'h40}, d);
      chk("wdtEnable", 8'h01, {7'h0, wdtEnable});
    end
    report_and_stop;
  end
endmodule : tb_top
